// *** tb/lsm_core_bench.sv ***
// Self-checking bench for the load/store access block
`timescale 1ns/100ps
`include "lsm_map.vh"
module lsm_core_bench;
	reg clk_sys = 1'b0, nrst = 1'b0, big_endian = 1'b0, wide_mode = 1'b1, user_mode = 1'b0, req_valid = 1'b0;
	reg fetch_or_data_flag = 1'b0, cop_access = 1'b0, cop_double = 1'b0, map_hit = 1'b0, map_writable = 1'b1;
	reg [2:0] req_op = 3'h0, access_size_code = 3'h0, map_cca = 3'h2;
	reg [31:0] virtual_addr = 32'h0, map_paddr = 32'h0;
	reg [63:0] store_data = 64'h0, cop_rdata = 64'h0;
	reg [1:0] cop_unit = 2'h1;
	reg [4:0] coproc_register_index = 5'h0, sync_type = 5'h0, pref_hint = 5'h0;
	reg [24:0] cop_function = 25'h0;
	reg [3:0] wait_cycles = 4'h0;
	wire req_ready, done_valid, exc_valid, mem_req, mem_write, mem_fill, mem_prefetch, mem_sync, mem_ack, cop_op_valid;
	wire coproc_word_load_transfer, coproc_double_load_transfer, coproc_word_store_transfer, coproc_double_store_transfer;
	wire [63:0] aligned_memory_element, mem_wdata, mem_rdata, cop_wdata;
	wire [7:0] load_byte_valid, mem_byte_en;
	wire [1:0] exc_code, cop_sel;
	wire [31:0] mem_addr;
	wire [2:0] mem_cca;
	wire [4:0] mem_hint, mem_sync_type, cop_reg;
	wire [24:0] cop_func_out;
	reg [63:0] s_wd;
	reg [31:0] s_addr;
	reg [7:0] s_be;
	reg [2:0] s_cca;
	integer fail_count = 0, n_checks = 0, k;
	lsm_core dut (.*);
	lsm_mem_model mem (.*);
	always #2.5 clk_sys = ~clk_sys;
	function [63:0] base(input [3:0] i);
		base = 64'h8877665544332211 + i;
	endfunction
	task check(input [63:0] got, input [63:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task run(input [2:0] op, input [31:0] va, input [2:0] sz, input [63:0] sd);
		begin
			@(posedge clk_sys);
			req_op <= op;
			virtual_addr <= va;
			access_size_code <= sz;
			store_data <= sd;
			req_valid <= 1'b1;
			@(posedge clk_sys);
			req_valid <= 1'b0;
			#1;
			for (k = 0; k < 400 && done_valid !== 1'b1; k = k + 1) begin
				if (mem_req === 1'b1) begin
					s_addr = mem_addr;
					s_be = mem_byte_en;
					s_wd = mem_wdata;
					s_cca = mem_cca;
				end
				@(posedge clk_sys);
				#1;
			end
			if (k >= 400) fail_count = fail_count + 1;
		end
	endtask
	task t_lanes;
		integer sz;
		begin
			for (sz = 0; sz < 8; sz = sz + 1) begin
				run(`LSM_OP_LOAD, 32'hA0000010, sz, 64'h0);
				check(s_be, (64'h1 << (sz + 1)) - 1);
				check(load_byte_valid, (64'h1 << (sz + 1)) - 1);
			end
			wait_cycles <= 4'h9;
			run(`LSM_OP_LOAD, 32'hA0000014, `LSM_SIZE_WORD, 64'h0);
			check({s_addr, s_be, s_cca}, {32'h00000010, 8'hF0, `LSM_CCA_UNCACHED});
			check(aligned_memory_element & 64'hFFFFFFFF00000000, base(2) & 64'hFFFFFFFF00000000);
			run(`LSM_OP_LOAD, 32'h80000018, `LSM_SIZE_DOUBLE, 64'h0);
			check({s_addr, s_cca}, {32'h00000018, `LSM_CCA_CACHED});
			$display("lanes done");
		end
	endtask
	task t_store;
		begin
			run(`LSM_OP_STORE, 32'hA0000013, `LSM_SIZE_HALF, 64'hFFFFFFFFFFFFBEEF);
			check(s_be, 8'h18);
			run(`LSM_OP_PREF, 32'hA0000010, `LSM_SIZE_DOUBLE, 64'h0);
			check(s_be, 8'h00);
			run(`LSM_OP_LOAD, 32'hA0000010, `LSM_SIZE_DOUBLE, 64'h0);
			check(aligned_memory_element, (base(2) & ~64'h000000FFFF000000) | 64'h000000BEEF000000);
			run(`LSM_OP_LOAD, 32'hA0000016, `LSM_SIZE_WORD, 64'h0);
			check(exc_code, 2'h2);
			$display("store done");
		end
	endtask
	task t_map;
		begin
			map_hit <= 1'b0;
			run(`LSM_OP_LOAD, 32'h00001000, `LSM_SIZE_WORD, 64'h0);
			check({exc_valid, exc_code}, 3'h5);
			map_hit <= 1'b1;
			map_paddr <= 32'h00003008;
			run(`LSM_OP_LOAD, 32'h00001008, `LSM_SIZE_WORD, 64'h0);
			check({s_addr, s_cca}, {32'h00003008, `LSM_CCA_UNCACHED});
			$display("map done");
		end
	endtask
	task t_cop;
		begin
			cop_unit <= 2'h2;
			cop_function <= 25'h1ABCDEF;
			run(`LSM_OP_COPOP, 32'h0, 3'h0, 64'h0);
			check(cop_func_out, 25'h1ABCDEF);
			cop_access <= 1'b1;
			cop_unit <= 2'h1;
			// Coprocessor hands its low word for the store
			cop_rdata <= 64'h12345678CAFEF00D;
			run(`LSM_OP_STORE, 32'hA0000020, `LSM_SIZE_WORD, 64'h0);
			check({s_be, s_wd[31:0]}, {8'h0F, 32'hCAFEF00D});
			cop_double <= 1'b1;
			run(`LSM_OP_STORE, 32'hA0000030, `LSM_SIZE_DOUBLE, 64'h0);
			check(s_wd, 64'h12345678CAFEF00D);
			cop_unit <= 2'h3;
			coproc_register_index <= 5'h07;
			run(`LSM_OP_LOAD, 32'hA0000028, `LSM_SIZE_DOUBLE, 64'h0);
			check({cop_wdata, cop_sel, cop_reg}, {base(5), 2'h3, 5'h07});
			cop_unit <= 2'h0;
			run(`LSM_OP_LOAD, 32'hA0000028, `LSM_SIZE_DOUBLE, 64'h0);
			check(exc_code, 2'h3);
			cop_access <= 1'b0;
			$display("cop done");
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", n_checks, fail_count);
			if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		t_lanes;
		t_store;
		t_map;
		t_cop;
		final_report;
	end
	initial begin
		#100000;
		fail_count = fail_count + 1;
		final_report;
	end
endmodule

// *** tb/lsm_core_chk.sv ***
// Port checker for the load/store access block
`timescale 1ns/100ps
`include "lsm_map.vh"
module lsm_core_chk (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Request
	input wire req_valid,
	input wire req_ready,
	input wire [2:0] req_op,
	input wire [2:0] access_size_code,
	input wire cop_access,
	input wire [1:0] cop_unit,
	input wire [24:0] cop_function,
	// Answers
	input wire done_valid,
	input wire mem_req,
	input wire mem_ack,
	input wire mem_fill,
	input wire mem_prefetch,
	input wire mem_sync,
	input wire [31:0] mem_addr,
	input wire [7:0] mem_byte_en,
	input wire coproc_word_load_transfer,
	input wire coproc_double_load_transfer,
	input wire coproc_word_store_transfer,
	input wire coproc_double_store_transfer,
	input wire cop_op_valid,
	input wire [1:0] cop_sel,
	input wire [24:0] cop_func_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire xfer = coproc_word_load_transfer | coproc_double_load_transfer | coproc_word_store_transfer
		| coproc_double_store_transfer;
	sequence s_mem_done;
		!mem_req ##1 done_valid;
	endsequence
	a_mem_hold: assert property (mem_req && !mem_ack |=> !mem_req || ($stable(mem_addr) && $stable(mem_byte_en)))
		else $error("memory request changed before ack");
	a_ack_done: assert property (mem_req && mem_ack |=> s_mem_done)
		else $error("no completion after memory ack");
	a_func_fwd: assert property (req_valid && req_ready && req_op == `LSM_OP_COPOP && cop_unit != 2'h0 |=>
		cop_op_valid && cop_func_out == $past(cop_function) && cop_sel == $past(cop_unit))
		else $error("function field not forwarded");
	a_op_done: assert property (cop_op_valid |=> done_valid)
		else $error("coprocessor op not completed");
	a_size_lanes: assert property ($rose(mem_req) && !mem_fill && !mem_prefetch && !mem_sync && !$past(cop_access)
		|-> $countones(mem_byte_en) == $past(access_size_code) + 1)
		else $error("lane count differs from size code");
	a_xfer_unit: assert property (xfer |-> cop_sel != `LSM_COP_SYSTEM)
		else $error("transfer to system coprocessor");
	a_done_pulse: assert property (done_valid |=> !done_valid)
		else $error("completion longer than one cycle");
	a_busy_ready: assert property (mem_req |-> !req_ready)
		else $error("request accepted while one outstanding");
endmodule
bind lsm_core lsm_core_chk chk (.*);

// *** tb/lsm_mem_model.sv ***
// Memory hierarchy stand-in with variable answer delay
`timescale 1ns/100ps
module lsm_mem_model (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Memory side
	input wire mem_req,
	input wire mem_write,
	input wire [31:0] mem_addr,
	input wire [7:0] mem_byte_en,
	input wire [63:0] mem_wdata,
	input wire [3:0] wait_cycles,
	output reg mem_ack,
	output reg [63:0] mem_rdata
);
	reg [63:0] mem [0:15];
	reg [3:0] cnt_reg;
	integer i;
	initial begin
		for (i = 0; i < 16; i = i + 1) begin
			mem[i] = 64'h8877665544332211 + i;
		end
	end
	always @(posedge clk_sys) begin
		mem_ack <= 1'b0;
		// Data is not held outside the ack cycle
		mem_rdata <= ~mem_rdata;
		if (!nrst) begin
			cnt_reg <= 4'h0;
			mem_rdata <= 64'h0;
		end else if (mem_req && !mem_ack) begin
			if (cnt_reg == wait_cycles) begin
				cnt_reg <= 4'h0;
				mem_ack <= 1'b1;
				mem_rdata <= mem[mem_addr[6:3]];
				for (i = 0; i < 8; i = i + 1) begin
					if (mem_write && mem_byte_en[i]) begin
						mem[mem_addr[6:3]][8*i+:8] <= mem_wdata[8*i+:8];
					end
				end
			end else begin
				cnt_reg <= cnt_reg + 4'h1;
			end
		end
	end
endmodule

// *** verilog/lsm_core.v ***
// Load/store access sequencer with coprocessor transfers
`timescale 1ns/100ps
`include "lsm_map.vh"
// Operation
// RULE_01 - object address is its lowest byte
// RULE_02 - endian picks byte at object address
// RULE_03 - three-bit size code, one to eight
// RULE_04 - lanes from size and low bits
// RULE_05 - unmapped addresses translate directly
// RULE_06 - mapped miss or denial raises exception
// RULE_07 - load returns register-width aligned element
// RULE_08 - uncached load reads only referenced bytes
// RULE_09 - cached miss fills whole element
// RULE_10 - store changes only selected bytes
// RULE_11 - partial store ignores unused lanes
// RULE_12 - prefetch never alters visible state; code still sets exc_valid and exc_code when a prefetch faults
// RULE_13 - sync orders loads and stores
// RULE_14 - word load goes to coprocessor
// RULE_15 - doubleword load goes to coprocessor
// RULE_16 - coprocessor supplies store word
// RULE_17 - coprocessor supplies store doubleword
// RULE_18 - forward function field unchanged
// RULE_19 - no transfers for system coprocessor
// RULE_20 - translation takes flags, returns address, attribute
module lsm_core (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Configuration
	input wire big_endian,
	input wire wide_mode,
	input wire user_mode,
	// Pipeline request
	input wire req_valid,
	output wire req_ready,
	input wire [2:0] req_op,
	input wire [31:0] virtual_addr,
	input wire fetch_or_data_flag,
	input wire [2:0] access_size_code,
	input wire [63:0] store_data,
	input wire cop_access,
	input wire cop_double,
	input wire [1:0] cop_unit,
	input wire [4:0] coproc_register_index,
	input wire [24:0] cop_function,
	input wire [4:0] sync_type,
	input wire [4:0] pref_hint,
	// Pipeline answer
	output reg done_valid,
	output reg [63:0] aligned_memory_element,
	output reg [7:0] load_byte_valid,
	output reg exc_valid,
	output reg [1:0] exc_code,
	// Mapped lookup
	input wire map_hit,
	input wire map_writable,
	input wire [31:0] map_paddr,
	input wire [2:0] map_cca,
	// Memory hierarchy
	output reg mem_req,
	output reg mem_write,
	output reg [31:0] mem_addr,
	output reg [7:0] mem_byte_en,
	output reg [63:0] mem_wdata,
	output reg [2:0] mem_cca,
	output reg mem_fill,
	output reg mem_prefetch,
	output reg [4:0] mem_hint,
	output reg mem_sync,
	output reg [4:0] mem_sync_type,
	input wire mem_ack,
	input wire [63:0] mem_rdata,
	// Coprocessor port
	output reg coproc_word_load_transfer,
	output reg coproc_double_load_transfer,
	output reg coproc_word_store_transfer,
	output reg coproc_double_store_transfer,
	output reg cop_op_valid,
	output reg [1:0] cop_sel,
	output reg [4:0] cop_reg,
	output reg [63:0] cop_wdata,
	output reg [24:0] cop_func_out,
	input wire [63:0] cop_rdata
);
	localparam ST_IDLE = 2'h0;
	localparam ST_MEM = 2'h1;
	localparam ST_DONE = 2'h2;
	localparam EXC_XLATE = 2'h1;
	localparam EXC_ALIGN = 2'h2;
	localparam EXC_COP = 2'h3;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [2:0] op_reg;
	reg cop_reg_access;
	reg cop_reg_double;
	reg [7:0] lanes_reg;
	reg [7:0] timer_reg;
	wire [7:0] lane_mask;
	wire lane_overflow;
	wire [31:0] phys_addr;
	wire [2:0] cca;
	wire xlate_fault;
	wire is_store;
	wire is_mem;
	wire cop_bad;
	wire [63:0] src_data;
	wire [63:0] lane_bits;
	wire [63:0] shifted_src;
	wire [5:0] shift_amt;
	reg [63:0] elem_next;
	integer i;

	assign is_store = (req_op == `LSM_OP_STORE);
	assign is_mem = (req_op == `LSM_OP_LOAD) || is_store;
	// RULE_19 system coprocessor excluded
	assign cop_bad = cop_access && (cop_unit == `LSM_COP_SYSTEM);
	assign req_ready = (state_reg == ST_IDLE);

	lsm_lane_gen u_lanes (
		.access_size_code(access_size_code),
		.addr_low(virtual_addr[2:0]),
		.big_endian(big_endian),
		.wide_mode(wide_mode),
		.lane_mask(lane_mask),
		.lane_overflow(lane_overflow)
	);

	lsm_xlate u_xlate (
		.virtual_addr(virtual_addr),
		.fetch_or_data_flag(fetch_or_data_flag),
		.load_or_store_flag(is_store),
		.user_mode(user_mode),
		.map_hit(map_hit),
		.map_writable(map_writable),
		.map_paddr(map_paddr),
		.map_cca(map_cca),
		.phys_addr(phys_addr),
		.cache_coherency_attribute(cca),
		.xlate_fault(xlate_fault)
	);

	// RULE_16 store word from coprocessor
	// RULE_17 store doubleword from coprocessor
	assign src_data = cop_access ? (cop_double ? cop_rdata : {32'h00000000, cop_rdata[31:0]}) : store_data;
	// RULE_01 lowest lane gets the object start
	assign shift_amt = {lowest_lane(lane_mask), 3'h0};
	assign shifted_src = big_endian ? swap_bytes(src_data, access_size_code) << shift_amt : src_data << shift_amt;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_lane
			assign lane_bits[g*8 +: 8] = {8{lane_mask[g]}};
		end
	endgenerate

	function [2:0] lowest_lane;
		input [7:0] m;
		integer k;
		begin
			lowest_lane = 3'h0;
			for (k = 7; k >= 0; k = k - 1) begin
				if (m[k]) begin
					lowest_lane = k[2:0];
				end
			end
		end
	endfunction

	// Reverse the used bytes so the first lane holds the most significant byte
	function [63:0] swap_bytes;
		input [63:0] d;
		input [2:0] sz;
		integer k;
		begin
			swap_bytes = 64'h0000000000000000;
			for (k = 0; k < 8; k = k + 1) begin
				if (k[2:0] <= sz) begin
					swap_bytes[k*8 +: 8] = d[(sz - k[2:0])*8 +: 8];
				end
			end
		end
	endfunction

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req_valid) begin
					if (req_op == `LSM_OP_COPOP) begin
						state_next = ST_DONE;
					end else if (xlate_fault || lane_overflow || cop_bad) begin
						state_next = ST_DONE;
					end else begin
						state_next = ST_MEM;
					end
				end
			end
			ST_MEM: begin
				if (mem_ack || timer_reg == `LSM_RESP_TIMEOUT) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @* begin
		elem_next = 64'h0000000000000000;
		for (i = 0; i < 8; i = i + 1) begin
			// RULE_08 only referenced bytes kept
			if (lanes_reg[i]) begin
				elem_next[i*8 +: 8] = mem_rdata[i*8 +: 8];
			end
		end
		if (!wide_mode) begin
			elem_next[63:32] = 32'h00000000;
		end
	end

	always @(posedge clk_sys) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			op_reg <= `LSM_OP_LOAD;
			cop_reg_access <= 1'b0;
			cop_reg_double <= 1'b0;
			lanes_reg <= 8'h00;
			timer_reg <= 8'h00;
			done_valid <= 1'b0;
			aligned_memory_element <= 64'h0000000000000000;
			load_byte_valid <= 8'h00;
			exc_valid <= 1'b0;
			exc_code <= 2'h0;
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_byte_en <= 8'h00;
			mem_wdata <= 64'h0000000000000000;
			mem_cca <= 3'h0;
			mem_fill <= 1'b0;
			mem_prefetch <= 1'b0;
			mem_hint <= 5'h00;
			mem_sync <= 1'b0;
			mem_sync_type <= 5'h00;
			coproc_word_load_transfer <= 1'b0;
			coproc_double_load_transfer <= 1'b0;
			coproc_word_store_transfer <= 1'b0;
			coproc_double_store_transfer <= 1'b0;
			cop_op_valid <= 1'b0;
			cop_sel <= 2'h0;
			cop_reg <= 5'h00;
			cop_wdata <= 64'h0000000000000000;
			cop_func_out <= 25'h0000000;
		end else begin
			state_reg <= state_next;
			done_valid <= 1'b0;
			coproc_word_load_transfer <= 1'b0;
			coproc_double_load_transfer <= 1'b0;
			coproc_word_store_transfer <= 1'b0;
			coproc_double_store_transfer <= 1'b0;
			cop_op_valid <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					timer_reg <= 8'h00;
					exc_valid <= 1'b0;
					if (req_valid) begin
						op_reg <= req_op;
						cop_reg_access <= cop_access;
						cop_reg_double <= cop_double;
						cop_sel <= cop_unit;
						cop_reg <= coproc_register_index;
						lanes_reg <= lane_mask;
						if (req_op == `LSM_OP_COPOP) begin
							// RULE_18 function field passed as is
							cop_func_out <= cop_function;
							cop_op_valid <= 1'b1;
						end else if (xlate_fault) begin
							// RULE_06 translation exception
							exc_valid <= 1'b1;
							exc_code <= EXC_XLATE;
						end else if (lane_overflow) begin
							exc_valid <= 1'b1;
							exc_code <= EXC_ALIGN;
						end else if (cop_bad) begin
							exc_valid <= 1'b1;
							exc_code <= EXC_COP;
						end else begin
							mem_req <= 1'b1;
							mem_addr <= {phys_addr[31:3], 3'h0};
							mem_cca <= cca;
							mem_write <= is_store;
							// RULE_10 only selected bytes enabled
							mem_byte_en <= is_mem ? lane_mask : 8'h00;
							// RULE_11 unused lanes driven zero
							mem_wdata <= shifted_src & lane_bits;
							// RULE_09 cached miss fills element
							mem_fill <= (req_op == `LSM_OP_LOAD) && (cca == `LSM_CCA_CACHED);
							// RULE_12 prefetch is advisory only
							mem_prefetch <= (req_op == `LSM_OP_PREF);
							mem_hint <= pref_hint;
							// RULE_13 sync barrier to hierarchy
							mem_sync <= (req_op == `LSM_OP_SYNC);
							mem_sync_type <= sync_type;
						end
					end
				end
				ST_MEM: begin
					timer_reg <= timer_reg + 8'h01;
					if (mem_ack || timer_reg == `LSM_RESP_TIMEOUT) begin
						mem_req <= 1'b0;
						mem_write <= 1'b0;
						mem_prefetch <= 1'b0;
						mem_sync <= 1'b0;
						mem_fill <= 1'b0;
						if (op_reg == `LSM_OP_LOAD) begin
							// RULE_07 register-width element back
							aligned_memory_element <= elem_next;
							load_byte_valid <= lanes_reg;
							// RULE_14 word to coprocessor
							coproc_word_load_transfer <= cop_reg_access && !cop_reg_double;
							// RULE_15 doubleword to coprocessor
							coproc_double_load_transfer <= cop_reg_access && cop_reg_double;
							cop_wdata <= elem_next;
						end
						if (op_reg == `LSM_OP_STORE && cop_reg_access) begin
							coproc_word_store_transfer <= !cop_reg_double;
							coproc_double_store_transfer <= cop_reg_double;
						end
					end
				end
				ST_DONE: begin
					done_valid <= 1'b1;
				end
				default: begin
					timer_reg <= 8'h00;
				end
			endcase
		end
	end
endmodule

// *** verilog/lsm_lane_gen.v ***
// Byte lane enable from size code and low address bits
`timescale 1ns/100ps
module lsm_lane_gen (
	// Access
	input wire [2:0] access_size_code,
	input wire [2:0] addr_low,
	input wire big_endian,
	input wire wide_mode,
	// Lanes
	output reg [7:0] lane_mask,
	output reg lane_overflow
);
	reg [15:0] span;
	reg [2:0] start;
	reg [7:0] lanes;
	always @* begin
		span = 16'h0000;
		start = wide_mode ? addr_low : {1'b0, addr_low[1:0]};
		// RULE_03 code plus one bytes
		// RULE_04 lanes from size and low bits
		span = ({8'h00, 8'hFF} >> (4'h7 - {1'b0, access_size_code})) << start;
		lanes = span[7:0];
		// RULE_02 big-endian mirrors lanes
		if (big_endian) begin
			lane_mask = wide_mode ? {lanes[0], lanes[1], lanes[2], lanes[3], lanes[4], lanes[5], lanes[6], lanes[7]}
				: {4'h0, lanes[0], lanes[1], lanes[2], lanes[3]};
		end else begin
			lane_mask = wide_mode ? lanes : {4'h0, lanes[3:0]};
		end
		lane_overflow = (span[15:8] != 8'h00) | (!wide_mode & (lanes[7:4] != 4'h0));
	end
endmodule

// *** verilog/lsm_map.vh ***
// Constants for the load/store memory access block
`ifndef LSM_MAP_VH
`define LSM_MAP_VH
// Access size codes
`define LSM_SIZE_BYTE 3'h0
`define LSM_SIZE_HALF 3'h1
`define LSM_SIZE_TRIPLE 3'h2
`define LSM_SIZE_WORD 3'h3
`define LSM_SIZE_QUINT 3'h4
`define LSM_SIZE_SEXT 3'h5
`define LSM_SIZE_SEPT 3'h6
`define LSM_SIZE_DOUBLE 3'h7
// Unmapped window: virtual bits [31:29] = 3'h4 or 3'h5
`define LSM_SEG_LO 3'h4
`define LSM_SEG_HI 3'h5
`define LSM_SEG_CACHED 3'h4
// Cache attribute codes
`define LSM_CCA_UNCACHED 3'h2
`define LSM_CCA_CACHED 3'h3
// Coprocessor numbers
`define LSM_COP_SYSTEM 2'h0
// Operation codes
`define LSM_OP_LOAD 3'h0
`define LSM_OP_STORE 3'h1
`define LSM_OP_PREF 3'h2
`define LSM_OP_SYNC 3'h3
`define LSM_OP_COPOP 3'h4
// Memory answer wait limit
`define LSM_RESP_TIMEOUT 8'hFF
`endif

// *** verilog/lsm_xlate.v ***
// Virtual to physical translation front end
`timescale 1ns/100ps
`include "lsm_map.vh"
module lsm_xlate (
	// Request
	input wire [31:0] virtual_addr,
	input wire fetch_or_data_flag,
	input wire load_or_store_flag,
	input wire user_mode,
	// Mapped lookup answer
	input wire map_hit,
	input wire map_writable,
	input wire [31:0] map_paddr,
	input wire [2:0] map_cca,
	// Result
	output reg [31:0] phys_addr,
	output reg [2:0] cache_coherency_attribute,
	output reg xlate_fault
);
	wire unmapped;
	assign unmapped = !user_mode && (virtual_addr[31:29] == `LSM_SEG_LO || virtual_addr[31:29] == `LSM_SEG_HI);
	always @* begin
		// RULE_20 both flags in, address and attribute out
		if (unmapped) begin
			// RULE_05 direct mapping, no table
			phys_addr = {3'h0, virtual_addr[28:0]};
			cache_coherency_attribute = (virtual_addr[31:29] == `LSM_SEG_CACHED) ? `LSM_CCA_CACHED : `LSM_CCA_UNCACHED;
			xlate_fault = 1'b0;
		end else begin
			phys_addr = map_paddr;
			cache_coherency_attribute = map_cca;
			// RULE_06 miss or denied store aborts
			xlate_fault = !map_hit || (load_or_store_flag && !map_writable && !fetch_or_data_flag);
		end
	end
endmodule
